/* pkg/teq_pkg.sv */
// package: register map, field layout and reset values of the tx event queue control
package teq_pkg;
  localparam logic [11:0] ADDR_CANCEL_IE = 12'h0e4;
  localparam logic [11:0] ADDR_CONFIG = 12'h0f0;
  localparam logic [11:0] ADDR_STATUS = 12'h0f4;
  localparam logic [11:0] ADDR_ACK = 12'h0f8;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h0fc;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h0e8;
  localparam int WM_LSB = 24;
  localparam int SIZE_LSB = 16;
  localparam int BASE_LSB = 2;
  localparam int BASE_MSB = 15;
  localparam int LOST_BIT = 25;
  localparam int FULL_BIT = 24;
  localparam int PUT_LSB = 16;
  localparam int GET_LSB = 8;
  localparam int FILL_LSB = 0;
  localparam int IRQ_WM_BIT = 0;
  localparam int IRQ_LOST_BIT = 1;
  localparam int IRQ_NEW_BIT = 2;
  localparam int IRQ_CANCEL_BIT = 3;
  localparam logic [5:0] MAX_ELEMENTS = 6'h20;
  localparam logic [31:0] CANCEL_IE_RESET = 32'h0000_0000;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [3:0] IRQ_RESET = 4'h0;
endpackage

/* rtl/teq_ctrl.sv */
// module: tx event queue bookkeeping with apb register file and interrupt
`timescale 1ns/1ps
`default_nettype none
module teq_ctrl #(
  parameter int IDX_W = 5,
  parameter int NUM_BUF = 32
) (
  // clock, reset, enable
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // event producer
  input wire logic elem_store_in,
  input wire logic [NUM_BUF-1:0] cancel_done_in,
  output logic [IDX_W-1:0] put_index_out,
  output logic [15:2] queue_base_word_out,
  output logic queue_enabled_out,
  output logic elem_accept_out,
  // cancel-done interrupt request, gated by per-buffer enables
  output logic cancel_irq_out,
  // block interrupt
  output logic irq_out
);

  // register state
  logic [31:0] cancel_ie_q;
  logic [31:0] cancel_ie_d;
  logic [5:0] wm_q;
  logic [5:0] wm_d;
  logic [5:0] size_q;
  logic [5:0] size_d;
  logic [15:2] base_q;
  logic [15:2] base_d;
  logic [3:0] irq_mask_q;
  logic [3:0] irq_mask_d;
  // queue state
  logic [IDX_W-1:0] put_q;
  logic [IDX_W-1:0] put_d;
  logic [IDX_W-1:0] get_q;
  logic [IDX_W-1:0] get_d;
  logic [IDX_W:0] fill_q;
  logic [IDX_W:0] fill_d;
  logic [IDX_W-1:0] ack_q;
  logic [IDX_W-1:0] ack_d;
  // interrupt and read data state
  logic [3:0] irq_stat_q;
  logic [3:0] irq_stat_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  // combinational helpers
  logic [31:0] rdata_mux;
  logic [31:0] status_word;
  logic [31:0] config_word;
  logic [IDX_W:0] eff_size;
  logic [IDX_W-1:0] put_next;
  logic [IDX_W-1:0] ack_next;
  logic [IDX_W-1:0] put_store;
  logic [IDX_W:0] fill_store;
  logic [IDX_W:0] fill_ack;
  logic [NUM_BUF-1:0] cancel_hit;
  logic access;
  logic wr_acc;
  logic rd_setup;
  // register select strobes
  logic sel_cancel_ie;
  logic sel_config;
  logic sel_status;
  logic sel_ack;
  logic sel_irq_stat;
  logic sel_irq_mask;
  logic hit;
  // event qualifiers
  logic q_on;
  logic full;
  logic do_store;
  logic lost_ev;
  logic wm_on;
  logic wm_ev;
  logic ack_wr;
  logic any_cancel;

  // apb access decode
  assign access = psel_in && penable_in;
  assign wr_acc = access && pwrite_in;
  assign rd_setup = psel_in && !penable_in && !pwrite_in;

  // register select, one strobe per mapped word
  always_comb begin
    sel_cancel_ie = (paddr_in == teq_pkg::ADDR_CANCEL_IE);
    sel_config = (paddr_in == teq_pkg::ADDR_CONFIG);
    sel_status = (paddr_in == teq_pkg::ADDR_STATUS);
    sel_ack = (paddr_in == teq_pkg::ADDR_ACK);
    sel_irq_stat = (paddr_in == teq_pkg::ADDR_IRQ_STATUS);
    sel_irq_mask = (paddr_in == teq_pkg::ADDR_IRQ_MASK);
    hit = sel_cancel_ie || sel_config || sel_status || sel_ack || sel_irq_stat
      || sel_irq_mask;
  end
  assign ack_wr = wr_acc && sel_ack;

  // effective size: clamp above the maximum, zero turns the queue off
  always_comb begin
    if (size_q > teq_pkg::MAX_ELEMENTS) begin
      eff_size = teq_pkg::MAX_ELEMENTS;
    end else begin
      eff_size = size_q;
    end
  end
  assign q_on = (eff_size != '0);

  // successor of the put index and of the acknowledged index
  teq_index_wrap #(.IDX_W(IDX_W)) u_put_wrap (
    .idx_in(put_q),
    .size_in(eff_size),
    .next_out(put_next)
  );
  teq_index_wrap #(.IDX_W(IDX_W)) u_ack_wrap (
    .idx_in(pwdata_in[IDX_W-1:0]),
    .size_in(eff_size),
    .next_out(ack_next)
  );

  // per-buffer cancel gating
  genvar gi;
  for (gi = 0; gi < NUM_BUF; gi++) begin : g_cancel
    assign cancel_hit[gi] = cancel_done_in[gi] && cancel_ie_q[gi];
  end
  assign any_cancel = |cancel_hit;

  // store acceptance and loss
  assign full = q_on && (fill_q >= eff_size);
  assign do_store = elem_store_in && q_on && !full;
  assign lost_ev = elem_store_in && (full || !q_on);

  // store stage: a new element advances put and fill
  always_comb begin
    put_store = put_q;
    fill_store = fill_q;
    if (do_store) begin
      put_store = put_next;
      fill_store = fill_q + 1'b1;
    end
  end

  // ack stage: fill recomputed from the new put and acked index plus one
  always_comb begin
    get_d = get_q;
    ack_d = ack_q;
    fill_ack = fill_store;
    if (ack_wr && q_on) begin
      ack_d = pwdata_in[IDX_W-1:0];
      get_d = ack_next;
      if (put_store == ack_next) begin
        fill_ack = '0;
      end else if (put_store > ack_next) begin
        fill_ack = {1'b0, put_store - ack_next};
      end else begin
        fill_ack = eff_size - {1'b0, ack_next} + {1'b0, put_store};
      end
    end
    if (!q_on) begin
      get_d = '0;
    end
  end

  // disable stage: size zero parks the queue empty at index zero
  always_comb begin
    put_d = put_store;
    fill_d = fill_ack;
    if (!q_on) begin
      put_d = '0;
      fill_d = '0;
    end
  end

  // watermark: only 1..max arms the interrupt
  assign wm_on = (wm_q != '0) && (wm_q <= teq_pkg::MAX_ELEMENTS);
  assign wm_ev = do_store && wm_on
    && (fill_d == wm_q);

  // interrupt enables and mask
  always_comb begin
    cancel_ie_d = cancel_ie_q;
    irq_mask_d = irq_mask_q;
    if (wr_acc && sel_cancel_ie) begin
      cancel_ie_d = pwdata_in;
    end
    if (wr_acc && sel_irq_mask) begin
      irq_mask_d = pwdata_in[3:0];
    end
  end

  // queue configuration
  always_comb begin
    wm_d = wm_q;
    size_d = size_q;
    base_d = base_q;
    if (wr_acc && sel_config) begin
      wm_d = pwdata_in[teq_pkg::WM_LSB +: 6];
      size_d = pwdata_in[teq_pkg::SIZE_LSB +: 6];
      base_d = pwdata_in[teq_pkg::BASE_MSB:teq_pkg::BASE_LSB];
    end
  end

  // sticky interrupt status, write one to clear
  always_comb begin
    irq_stat_d = irq_stat_q;
    if (wr_acc && sel_irq_stat) begin
      irq_stat_d = irq_stat_q & ~pwdata_in[3:0];
    end
    // event sets come last so they win over the clear
    if (wm_ev) begin
      irq_stat_d[teq_pkg::IRQ_WM_BIT] = 1'b1;
    end
    if (lost_ev) begin
      irq_stat_d[teq_pkg::IRQ_LOST_BIT] = 1'b1;
    end
    if (do_store) begin
      irq_stat_d[teq_pkg::IRQ_NEW_BIT] = 1'b1;
    end
    if (any_cancel) begin
      irq_stat_d[teq_pkg::IRQ_CANCEL_BIT] = 1'b1;
    end
  end

  // status word: flags, indices and fill level
  always_comb begin
    status_word = '0;
    status_word[teq_pkg::LOST_BIT] = irq_stat_q[teq_pkg::IRQ_LOST_BIT];
    status_word[teq_pkg::FULL_BIT] = full;
    status_word[teq_pkg::PUT_LSB +: IDX_W] = put_q;
    status_word[teq_pkg::GET_LSB +: IDX_W] = get_q;
    status_word[teq_pkg::FILL_LSB +: IDX_W+1] = fill_q;
  end

  // configuration readback
  always_comb begin
    config_word = '0;
    config_word[teq_pkg::WM_LSB +: 6] = wm_q;
    config_word[teq_pkg::SIZE_LSB +: 6] = size_q;
    config_word[teq_pkg::BASE_MSB:teq_pkg::BASE_LSB] = base_q;
  end

  // read mux
  always_comb begin
    rdata_mux = '0;
    case (paddr_in)
      teq_pkg::ADDR_CANCEL_IE: rdata_mux = cancel_ie_q;
      teq_pkg::ADDR_CONFIG: rdata_mux = config_word;
      teq_pkg::ADDR_STATUS: rdata_mux = status_word;
      teq_pkg::ADDR_ACK: rdata_mux[IDX_W-1:0] = ack_q;
      teq_pkg::ADDR_IRQ_STATUS: rdata_mux[3:0] = irq_stat_q;
      teq_pkg::ADDR_IRQ_MASK: rdata_mux[3:0] = irq_mask_q;
      default: rdata_mux = '0;
    endcase
  end

  // read data taken in the setup cycle, stands until the next read
  always_comb begin
    rdata_d = rdata_q;
    if (rd_setup) begin
      rdata_d = rdata_mux;
    end
  end

  // interrupt enable registers
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cancel_ie_q <= teq_pkg::CANCEL_IE_RESET;
      irq_mask_q <= teq_pkg::IRQ_RESET;
    end else if (clk_en_in) begin
      cancel_ie_q <= cancel_ie_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  // configuration registers
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wm_q <= teq_pkg::CONFIG_RESET[teq_pkg::WM_LSB +: 6];
      size_q <= teq_pkg::CONFIG_RESET[teq_pkg::SIZE_LSB +: 6];
      base_q <= teq_pkg::CONFIG_RESET[teq_pkg::BASE_MSB:teq_pkg::BASE_LSB];
    end else if (clk_en_in) begin
      wm_q <= wm_d;
      size_q <= size_d;
      base_q <= base_d;
    end
  end

  // queue pointers and fill
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      put_q <= '0;
      get_q <= '0;
      fill_q <= '0;
      ack_q <= '0;
    end else if (clk_en_in) begin
      put_q <= put_d;
      get_q <= get_d;
      fill_q <= fill_d;
      ack_q <= ack_d;
    end
  end

  // interrupt status
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_stat_q <= teq_pkg::IRQ_RESET;
    end else if (clk_en_in) begin
      irq_stat_q <= irq_stat_d;
    end
  end

  // read data
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_q <= '0;
    end else if (clk_en_in) begin
      rdata_q <= rdata_d;
    end
  end

  // apb responses
  assign prdata_out = rdata_q;
  assign pready_out = 1'b1;
  assign pslverr_out = access && !hit;
  // producer side
  assign put_index_out = put_q;
  assign queue_base_word_out = base_q;
  assign queue_enabled_out = q_on;
  assign elem_accept_out = do_store;
  // interrupts
  assign cancel_irq_out = any_cancel;
  assign irq_out = |(irq_stat_q & irq_mask_q);
endmodule
`default_nettype wire

/* rtl/teq_index_wrap.sv */
// module: index increment with wrap inside a programmable queue size
`timescale 1ns/1ps
`default_nettype none
module teq_index_wrap #(
  parameter int IDX_W = 5
) (
  // index and size
  input wire logic [IDX_W-1:0] idx_in,
  input wire logic [IDX_W:0] size_in,
  // wrapped successor
  output logic [IDX_W-1:0] next_out
);
  logic [IDX_W:0] sum;
  always_comb begin
    sum = {1'b0, idx_in} + {{IDX_W{1'b0}}, 1'b1};
    if (sum >= size_in) begin
      next_out = '0;
    end else begin
      next_out = sum[IDX_W-1:0];
    end
  end
endmodule
`default_nettype wire

/* test/teq_checker.sv */
// checker: port assertions of the event queue control
`timescale 1ns/1ps
`default_nettype none
module teq_checker #(
  parameter int IDX_W = 5,
  parameter int NUM_BUF = 32
) (
  // clock, reset, enable
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  // apb
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pslverr_out,
  // producer side
  input wire logic elem_store_in,
  input wire logic [NUM_BUF-1:0] cancel_done_in,
  input wire logic [IDX_W-1:0] put_index_out,
  input wire logic [15:2] queue_base_word_out,
  input wire logic queue_enabled_out,
  input wire logic elem_accept_out,
  input wire logic cancel_irq_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire logic cfg_wr = psel_in && penable_in && pwrite_in && clk_en_in
    && paddr_in == teq_pkg::ADDR_CONFIG;
  a_err_scope: assert property (pslverr_out |-> psel_in && penable_in)
    else $error("error outside access");
  a_err_unmapped: assert property (psel_in && penable_in && paddr_in == 12'h0ec |-> pslverr_out)
    else $error("no error on hole");
  a_cancel_gate: assert property (cancel_done_in == '0 |-> !cancel_irq_out)
    else $error("cancel irq without event");
  a_accept_cause: assert property (elem_accept_out |-> elem_store_in && queue_enabled_out)
    else $error("accept without store");
  a_put_stable: assert property (!elem_accept_out && !cfg_wr |=> $stable(put_index_out))
    else $error("put index moved");
  a_base_word: assert property (cfg_wr |=> queue_base_word_out == $past(pwdata_in[15:2]))
    else $error("base word wrong");
  a_size_zero: assert property (cfg_wr && pwdata_in[21:16] == 6'h0 |=>
    !queue_enabled_out && put_index_out == '0) else $error("size zero not off");
  a_size_live: assert property (cfg_wr && pwdata_in[21:16] != 6'h0 |=> queue_enabled_out)
    else $error("size not on");
  c_accept: cover property (elem_accept_out);
  c_lost: cover property (elem_store_in && !queue_enabled_out);
  c_err: cover property (pslverr_out);
endmodule
`default_nettype wire

/* test/teq_producer.sv */
// partner: event producer giving stores and cancel-done events
`timescale 1ns/1ps
`default_nettype none
module teq_producer (
  // clock
  input wire logic clk_in,
  // events
  output logic store_out,
  output logic [31:0] cancel_out
);
  initial begin
    store_out = 1'b0;
    cancel_out = 32'h0;
  end
  task emit(input int n);
    repeat (n) @(posedge clk_in) store_out <= 1'b1;
    @(posedge clk_in) store_out <= 1'b0;
  endtask
  task cancel(input logic [31:0] b);
    @(posedge clk_in) cancel_out <= b;
  endtask
endmodule
`default_nettype wire

/* test/testbench.sv */
// testbench: register and queue scenarios of the event queue control
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 0, rst_n = 0, en = 1, psel = 0, pen = 0, pwr = 0;
  logic [11:0] pa = 12'h0;
  logic [31:0] pwd = 32'h0, prd, prdata, canc;
  logic pready, perr, err_seen, store, qen, acc, cirq, irq;
  logic [4:0] put;
  logic [15:2] base;
  int fails = 0, n_checks = 0;
  always #4 clk = ~clk;
  teq_producer P (.clk_in(clk), .store_out(store), .cancel_out(canc));
  teq_ctrl DUT (.core_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(en), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr), .elem_store_in(store),
    .cancel_done_in(canc), .put_index_out(put), .queue_base_word_out(base),
    .queue_enabled_out(qen), .elem_accept_out(acc), .cancel_irq_out(cirq), .irq_out(irq));
  task wrap_up;
    if (fails == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      fails++;
      wrap_up;
    end
    prd = prdata;
    err_seen = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(prd, e);
  endtask
  task rs(input logic [31:0] e);
    rd(teq_pkg::ADDR_STATUS, e);
  endtask
  // lost, full, put, get, fill packed as the status word
  function logic [31:0] st(logic l, logic f, logic [4:0] p, logic [4:0] g, logic [5:0] n);
    return {6'h0, l, f, 3'h0, p, 3'h0, g, 2'h0, n};
  endfunction
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(teq_pkg::ADDR_CANCEL_IE, 32'h0);
    rs(32'h0);
    rd(12'h0ec, 32'h0);
    chk(32'(err_seen), 32'h1);
    P.emit(1);
    rs(st(1'b1, 1'b0, 5'h0, 5'h0, 6'h0));
    xfer(1'b1, teq_pkg::ADDR_IRQ_MASK, 32'h3);
    #1 chk(32'(irq), 32'h1);
    xfer(1'b1, teq_pkg::ADDR_IRQ_STATUS, 32'h2);
    rs(32'h0);
    xfer(1'b1, teq_pkg::ADDR_CONFIG, 32'h213f_0000);
    P.emit(32);
    rs(st(1'b0, 1'b1, 5'h0, 5'h0, 6'h20));
    rd(teq_pkg::ADDR_IRQ_STATUS, 32'h4);
    xfer(1'b1, teq_pkg::ADDR_ACK, 32'h1f);
    rs(32'h0);
    xfer(1'b1, teq_pkg::ADDR_IRQ_STATUS, 32'hf);
    xfer(1'b1, teq_pkg::ADDR_CONFIG, 32'h0204_48d0);
    #1 chk(32'(base), 32'h1234);
    chk(32'(qen), 32'h1);
    P.emit(3);
    #1 chk(32'(put), 32'h3);
    rd(teq_pkg::ADDR_IRQ_STATUS, 32'h5);
    P.emit(2);
    rs(st(1'b1, 1'b1, 5'h0, 5'h0, 6'h4));
    xfer(1'b1, teq_pkg::ADDR_ACK, 32'h2);
    rs(st(1'b1, 1'b0, 5'h0, 5'h3, 6'h1));
    xfer(1'b1, teq_pkg::ADDR_CONFIG, 32'h0);
    rs(st(1'b1, 1'b0, 5'h0, 5'h0, 6'h0));
    #1 chk(32'(qen), 32'h0);
    en <= 1'b0;
    xfer(1'b1, teq_pkg::ADDR_CANCEL_IE, 32'h4);
    en <= 1'b1;
    rd(teq_pkg::ADDR_CANCEL_IE, 32'h0);
    xfer(1'b1, teq_pkg::ADDR_CANCEL_IE, 32'h4);
    P.cancel(32'h4);
    #1 chk(32'(cirq), 32'h1);
    P.cancel(32'h8);
    #1 chk(32'(cirq), 32'h0);
    P.cancel(32'h0);
    wrap_up;
  end
endmodule
bind teq_ctrl teq_checker #(.IDX_W(IDX_W), .NUM_BUF(NUM_BUF)) u_chk (.*);
`default_nettype wire
